//--- hdl/hoc_pkg.sv
/*
 * Shared constants and carriers for the hold-off counter block:
 * register offsets, field positions, reset values, tick prescaler limits
 * and the byte-wide configuration access struct.
 * Assumes the configuration port is the device's internal byte register path.
 */
package hoc_pkg;

    // register byte addresses
    localparam logic [7:0] HOLDOFF_COUNT_ADDR = 8'h16;
    localparam logic [7:0] HOLDOFF_DIV_ADDR = 8'h17;

    // divider field position inside its register byte
    localparam int HOLDOFF_DIV_MSB = 7;
    localparam int HOLDOFF_DIV_LSB = 6;

    // values after reset
    localparam logic [7:0] HOLDOFF_COUNT_RST = 8'h80;
    localparam logic [1:0] HOLDOFF_DIV_RST = 2'h2;

    // reference selection mode codes
    localparam logic [1:0] MODE_AUTO_HOLDOVER = 2'h3;

    // tick divider codes
    localparam logic [1:0] DIV_CODE_2P15 = 2'h0;
    localparam logic [1:0] DIV_CODE_2P16 = 2'h1;

    // prescaler terminal counts: division ratio minus one
    localparam logic [16:0] PRE_LAST_2P15 = 17'h07FFF;
    localparam logic [16:0] PRE_LAST_2P16 = 17'h0FFFF;
    localparam logic [16:0] PRE_LAST_2P17 = 17'h1FFFF;

    // one register access, synchronous to mclk
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hoc_reg_req_s;

    typedef enum logic [1:0] {
        HOC_IDLE = 2'b01,
        HOC_COUNT = 2'b10
    } hoc_state_e;

endpackage

//--- hdl/hoc_tick_prescaler.sv
/*
 * Prescaler that turns the VCXO-PLL output clock into the hold-off tick.
 * Assumes mclk is the VCXO-PLL output clock and run stays high while counting.
 */
`timescale 1ns/1ps
module hoc_tick_prescaler (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [1:0] div_code,
    output logic tick
);

    logic [16:0] pre_q;
    logic [16:0] pre_d;
    logic [16:0] pre_last;

    ////////////////////////////////////////////////////////////////////////
    // terminal count per divider code; the spare code 11 falls back to 2^17
    always_comb
    begin
        pre_last = hoc_pkg::PRE_LAST_2P17;
        if (div_code == hoc_pkg::DIV_CODE_2P15)
        begin
            pre_last = hoc_pkg::PRE_LAST_2P15; // R6
        end
        else if (div_code == hoc_pkg::DIV_CODE_2P16)
        begin
            pre_last = hoc_pkg::PRE_LAST_2P16; // R6
        end
    end

    // held at zero while idle so every countdown starts with a whole tick
    assign tick = run && (pre_q >= pre_last); // R4
    always_comb
    begin
        pre_d = (!run || tick) ? 17'h00000 : pre_q + 17'h00001;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_q <= 17'h00000;
        end
        else
        begin
            pre_q <= pre_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_tick_code_2p15: assert property (@(posedge mclk) disable iff (!nrst) // R6
        (tick && div_code == 2'h0 && $past(run) && $past(div_code) == 2'h0) |-> $past(pre_q) == 17'h07FFE)
        else $error("tick at wrong count for divide by 2^15");
    a_tick_code_2p17: assert property (@(posedge mclk) disable iff (!nrst) // R7
        (tick && div_code == 2'h2 && $past(run) && $past(div_code) == 2'h2) |-> $past(pre_q) == 17'h1FFFE)
        else $error("tick at wrong count for divide by 2^17");

endmodule

//--- hdl/hoc_holdoff_counter.sv
/*
 * Hold-off counter for automatic reference selection with holdover.
 * Holds the hold-off count and tick divider registers, counts down after a
 * loss of signal on the active reference and requests a fail-over on expiry.
 * Assumes mclk is the VCXO-PLL output, all inputs are synchronous to it and
 * the selection logic acts on failover_req and then reports the new LOS state.
 */
// How it works
// R1: counter runs only when selection mode is automatic with holdover, code 11.
// R2: a loss-of-signal event on the active reference starts the countdown.
// R3: reaching zero requests a fail-over to another reference input.
// R4: period is programmed count times tick, one tick for a count of 0; count resets to 0x80.
// R5: after each zero transition the counter reloads the programmed count.
// R6: divider code 00 ticks at VCXO/2^15, code 01 at VCXO/2^16.
// R7: divider field resets to code 10, giving VCXO/2^17 ticks.
// R8: reference recovery before zero aborts the countdown and reloads without switching.
`timescale 1ns/1ps
module hoc_holdoff_counter (
    input wire logic mclk,
    input wire logic nrst,
    input wire hoc_pkg::hoc_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] ref_selection_mode_field,
    input wire logic active_ref_los,
    output logic failover_req,
    output logic holdoff_active,
    output logic [7:0] holdoff_remaining
);

    logic [7:0] holdoff_count_q;
    logic [7:0] holdoff_count_d;
    logic [1:0] holdoff_tick_divider_q;
    logic [1:0] holdoff_tick_divider_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    hoc_pkg::hoc_state_e state_q;
    hoc_pkg::hoc_state_e state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic los_q;
    logic los_d;
    logic fail_q;
    logic fail_d;
    logic enabled;
    logic los_event;
    logic tick;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers and read path
    always_comb
    begin
        holdoff_count_d = holdoff_count_q;
        holdoff_tick_divider_d = holdoff_tick_divider_q;
        rdata_d = rdata_q;
        if (reg_req.wr && reg_req.addr == hoc_pkg::HOLDOFF_COUNT_ADDR)
        begin
            holdoff_count_d = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == hoc_pkg::HOLDOFF_DIV_ADDR)
        begin
            holdoff_tick_divider_d = reg_req.wdata[hoc_pkg::HOLDOFF_DIV_MSB:hoc_pkg::HOLDOFF_DIV_LSB];
        end
        if (reg_req.rd)
        begin
            // other fields sharing these bytes live elsewhere and read as zero here
            unique case (reg_req.addr)
                hoc_pkg::HOLDOFF_COUNT_ADDR: rdata_d = holdoff_count_q;
                hoc_pkg::HOLDOFF_DIV_ADDR: rdata_d = {holdoff_tick_divider_q, 6'h00};
                default: rdata_d = 8'h00; // unmapped
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            holdoff_count_q <= hoc_pkg::HOLDOFF_COUNT_RST; // R4
            holdoff_tick_divider_q <= hoc_pkg::HOLDOFF_DIV_RST; // R7
            rdata_q <= 8'h00;
        end
        else
        begin
            holdoff_count_q <= holdoff_count_d;
            holdoff_tick_divider_q <= holdoff_tick_divider_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // tick source; stopped outside a countdown
    hoc_tick_prescaler i_hoc_tick_prescaler (
        .mclk(mclk),
        .nrst(nrst),
        .run(state_q == hoc_pkg::HOC_COUNT),
        .div_code(holdoff_tick_divider_q),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // countdown state machine
    assign enabled = (ref_selection_mode_field == hoc_pkg::MODE_AUTO_HOLDOVER); // R1
    assign los_event = active_ref_los && !los_q; // R2

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        fail_d = 1'b0;
        los_d = active_ref_los;
        unique case (state_q)
            hoc_pkg::HOC_IDLE:
            begin
                cnt_d = holdoff_count_q;
                if (enabled && los_event)
                begin
                    state_d = hoc_pkg::HOC_COUNT; // R2
                end
            end
            hoc_pkg::HOC_COUNT:
            begin
                if (!enabled)
                begin
                    state_d = hoc_pkg::HOC_IDLE; // R1
                    cnt_d = holdoff_count_q;
                end
                else if (!active_ref_los)
                begin
                    // reference came back: abandon quietly
                    state_d = hoc_pkg::HOC_IDLE; // R8
                    cnt_d = holdoff_count_q;
                end
                else if (tick)
                begin
                    // a programmed zero expires on the first tick rather than wrapping
                    if (cnt_q <= 8'h01)
                    begin
                        fail_d = 1'b1; // R3
                        cnt_d = holdoff_count_q; // R5
                        state_d = hoc_pkg::HOC_IDLE;
                    end
                    else
                    begin
                        cnt_d = cnt_q - 8'h01; // R4
                    end
                end
            end
            default:
            begin
                state_d = hoc_pkg::HOC_IDLE;
                cnt_d = holdoff_count_q;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= hoc_pkg::HOC_IDLE;
            cnt_q <= hoc_pkg::HOLDOFF_COUNT_RST;
            los_q <= 1'b0;
            fail_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            los_q <= los_d;
            fail_q <= fail_d;
        end
    end

    assign failover_req = fail_q;
    assign holdoff_active = (state_q == hoc_pkg::HOC_COUNT);
    assign holdoff_remaining = cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_idle_when_off: assert property (@(posedge mclk) disable iff (!nrst) // R1
        !enabled |=> !holdoff_active && !failover_req)
        else $error("hold-off counter active outside auto holdover mode");
    a_start_on_los: assert property (@(posedge mclk) disable iff (!nrst) // R2
        (!holdoff_active && enabled && los_event) |=> holdoff_active && cnt_q == $past(holdoff_count_q))
        else $error("countdown did not start on loss of signal");
    a_fail_at_zero: assert property (@(posedge mclk) disable iff (!nrst) // R3
        (holdoff_active && enabled && active_ref_los && tick && cnt_q == 8'h01) |=> failover_req)
        else $error("no fail-over at zero transition");
    a_fail_has_cause: assert property (@(posedge mclk) disable iff (!nrst) // R3
        failover_req |-> $past(holdoff_active) && $past(tick) && $past(active_ref_los))
        else $error("fail-over without expiry");
    a_tick_decrement: assert property (@(posedge mclk) disable iff (!nrst) // R4
        (holdoff_active && enabled && active_ref_los && tick && cnt_q > 8'h01) |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("countdown did not step by one");
    a_reset_values: assert property (@(posedge mclk) // R4 R7
        $rose(nrst) |-> holdoff_count_q == 8'h80 && holdoff_tick_divider_q == 2'h2)
        else $error("register reset values wrong");
    a_reload_zero: assert property (@(posedge mclk) disable iff (!nrst) // R5
        failover_req |-> !holdoff_active && cnt_q == $past(holdoff_count_q))
        else $error("counter not reloaded after zero transition");
    a_recover_abort: assert property (@(posedge mclk) disable iff (!nrst) // R8
        (holdoff_active && enabled && !active_ref_los) |=> !holdoff_active && !failover_req
            && cnt_q == $past(holdoff_count_q))
        else $error("recovery did not abort countdown");
    // a mode change in mid-countdown must drop it without a request
    a_mode_leave_abort: assert property (@(posedge mclk) disable iff (!nrst) // R1
        (holdoff_active && !enabled) |=> !holdoff_active && !failover_req && cnt_q == $past(holdoff_count_q))
        else $error("leaving auto holdover mode did not abort countdown");
    // a los level held past expiry or abort must not start a second countdown
    a_start_needs_edge: assert property (@(posedge mclk) disable iff (!nrst) // R2
        (!holdoff_active && !(enabled && los_event)) |=> !holdoff_active)
        else $error("countdown started without a loss-of-signal edge");

    // main scenarios the bench is expected to reach
    c_start: cover property (@(posedge mclk) disable iff (!nrst) $rose(holdoff_active));
    c_failover: cover property (@(posedge mclk) disable iff (!nrst) failover_req);
    c_abort: cover property (@(posedge mclk) disable iff (!nrst) holdoff_active && !active_ref_los && enabled);
    c_mode_abort: cover property (@(posedge mclk) disable iff (!nrst) holdoff_active && !enabled);

endmodule

//--- testbench/holdover_holdoff_counter_tb.sv
/*
 * Self-checking bench for the hold-off counter: register access, mode gating,
 * countdown to fail-over with exact cycle count, reload and abort on recovery.
 * Assumes the design counts whole mclk cycles and that the divider ratios
 * are fixed, so only the 2^15 code is run to expiry to keep the run short.
 */
`timescale 1ns/1ps
module holdover_holdoff_counter_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    hoc_pkg::hoc_reg_req_s reg_req = '0;
    logic [7:0] reg_rdata;
    logic [1:0] mode = 2'h0;
    logic los = 1'b0;
    logic failover_req;
    logic holdoff_active;
    logic [7:0] holdoff_remaining;
    logic [7:0] rv;
    int n_mismatch = 0;
    int compares = 0;
    int n_fo = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock at 125 MHz
    always #4 mclk = ~mclk;

    hoc_holdoff_counter i_hoc_holdoff_counter (
        .mclk(mclk),
        .nrst(nrst),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .ref_selection_mode_field(mode),
        .active_ref_los(los),
        .failover_req(failover_req),
        .holdoff_active(holdoff_active),
        .holdoff_remaining(holdoff_remaining)
    );

    // every pulse is counted so a stray request never slips by unseen
    always @(posedge mclk)
    begin
        if (failover_req === 1'b1)
            n_fo <= n_fo + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // inputs always change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // strobes are dropped one edge before the next access can raise them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        step(1);
        reg_req.wr = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        step(1);
        reg_req.rd = 1'b0;
        rv = reg_rdata;
        step(1);
    endtask

    // raise los, then time the countdown from the first active cycle
    task automatic run_out(input logic [7:0] n, input int ratio);
        int c = 0;
        los = 1'b1;
        step(1);
        chk("active at start", 17'(holdoff_active), 17'h00001);
        chk("loaded count", 17'(holdoff_remaining), 17'(n));
        while (failover_req !== 1'b1 && c < ratio * 2)
        begin
            step(1);
            c++;
        end
        chk("expiry cycles", 17'(c), 17'(ratio * n));
        chk("active after expiry", 17'(holdoff_active), 17'h00000);
        chk("reloaded count", 17'(holdoff_remaining), 17'(n));
        step(4);
        chk("no restart on level", 17'(holdoff_active), 17'h00000);
        los = 1'b0;
        step(1);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        step(20);
        nrst = 1'b1;
        step(1);
        rd(hoc_pkg::HOLDOFF_COUNT_ADDR);
        chk("count reset", 17'(rv), 17'h00080);
        rd(hoc_pkg::HOLDOFF_DIV_ADDR);
        chk("divider reset", 17'(rv), 17'h00080);
        rd(8'h20);
        chk("unmapped read", 17'(rv), 17'h00000);
        wr(hoc_pkg::HOLDOFF_COUNT_ADDR, 8'h01);
        rd(hoc_pkg::HOLDOFF_COUNT_ADDR);
        chk("count write", 17'(rv), 17'h00001);
        wr(hoc_pkg::HOLDOFF_DIV_ADDR, 8'hFF);
        rd(hoc_pkg::HOLDOFF_DIV_ADDR);
        chk("divider spare bits", 17'(rv), 17'h000C0);
        wr(hoc_pkg::HOLDOFF_DIV_ADDR, 8'h00);
        $display("test registers done");
        for (int m = 0; m < 3; m++)
        begin
            mode = m[1:0];
            los = 1'b1;
            step(3);
            chk("ignored mode", 17'(holdoff_active), 17'h00000);
            los = 1'b0;
            step(1);
        end
        chk("no pulse off mode", 17'(n_fo), 17'h00000);
        $display("test mode gating done");
        mode = hoc_pkg::MODE_AUTO_HOLDOVER;
        step(1);
        run_out(8'h01, 32768);
        chk("one pulse", 17'(n_fo), 17'h00001);
        $display("test expiry done");
        wr(hoc_pkg::HOLDOFF_DIV_ADDR, 8'h40);
        rd(hoc_pkg::HOLDOFF_DIV_ADDR);
        chk("divider 2^16", 17'(rv), 17'h00040);
        los = 1'b1;
        step(33000);
        chk("still counting", 17'(holdoff_active), 17'h00001);
        los = 1'b0;
        step(2);
        chk("aborted", 17'(holdoff_active), 17'h00000);
        chk("abort reload", 17'(holdoff_remaining), 17'h00001);
        step(10);
        chk("no pulse on abort", 17'(n_fo), 17'h00001);
        los = 1'b1;
        step(3);
        chk("restart on new edge", 17'(holdoff_active), 17'h00001);
        mode = 2'h1;
        step(2);
        chk("mode leave abort", 17'(holdoff_active), 17'h00000);
        los = 1'b0;
        mode = hoc_pkg::MODE_AUTO_HOLDOVER;
        step(10);
        chk("no pulse on mode leave", 17'(n_fo), 17'h00001);
        $display("test abort done");
        summarize();
    end

    // the tests take about 66000 cycles; give up well beyond that
    initial
    begin
        #800000;
        n_mismatch++;
        summarize();
    end
endmodule
